// file: hw/tlc_pkg.sv
// Purpose: shared constants and carriers of the two-loop temperature control block
// Assumes: 50 MHz mclk, apb register bus with 32-bit data
// Notes:   all offsets are byte addresses of aligned words
package tlc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int MS_NS           = 1000000;
  localparam int CYC_PER_MS      = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOTS_PER_PERIOD = 1000;            // drive level resolution, tenths of a percent

  // register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_PERIOD1 = 8'h10;
  localparam logic [7:0] OFS_PERIOD2 = 8'h14;
  localparam logic [7:0] OFS_TARGET1 = 8'h18;
  localparam logic [7:0] OFS_TARGET2 = 8'h1c;
  localparam logic [7:0] OFS_BAND1   = 8'h20;
  localparam logic [7:0] OFS_BAND2   = 8'h24;
  localparam logic [7:0] OFS_DRIVE1  = 8'h28;
  localparam logic [7:0] OFS_DRIVE2  = 8'h2c;

  // field positions of the status word
  localparam int ST_TYPE_LSB = 0;
  localparam int ST_FAHR     = 4;
  localparam int ST_FMT      = 5;
  localparam int ST_FWD_LSB  = 6;
  localparam int ST_ONOFF    = 8;
  localparam int ST_BADTYPE  = 9;
  localparam int ST_ERR      = 10;
  localparam int ST_ERRN_LSB = 12;
  localparam int ST_OUT_LSB  = 16;

  // reset values and setting limits
  localparam logic [1:0]  RST_STOP    = 2'h3;
  localparam logic [15:0] RST_PERIOD  = 16'h0014;
  localparam logic [15:0] RST_TARGET  = 16'h0000;
  localparam logic [15:0] RST_BAND    = 16'h0008;
  localparam logic [15:0] RST_DRIVE   = 16'h0000;
  localparam logic [15:0] PERIOD_MIN  = 16'h0001;
  localparam logic [15:0] PERIOD_MAX  = 16'h0063;
  localparam logic [15:0] BAND_MAX    = 16'h270f;
  localparam logic [15:0] DRIVE_MAX   = 16'h03e8;
  localparam logic [3:0]  TC_TYPE_MAX = 4'h9;
  localparam logic [3:0]  RTD_TYPE_MAX = 4'h1;

  // setting error numbers
  localparam logic [3:0] ERRN_PERIOD = 4'h1;
  localparam logic [3:0] ERRN_TARGET = 4'h2;
  localparam logic [3:0] ERRN_BAND   = 4'h3;
  localparam logic [3:0] ERRN_DRIVE  = 4'h4;

  // front-panel selections as caught at reset
  typedef struct packed {
    logic [3:0] input_type;
    logic       fahrenheit;
    logic       data_format;
    logic [1:0] forward;
    logic       onoff;
  } tlc_cfg_t;

  // per-loop settings written by the host
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] target;
    logic [15:0] band;
    logic [15:0] drive;
  } tlc_loop_set_t;

endpackage

// file: hw/tlc_loop.sv
// Purpose: one control loop, on/off with hysteresis or time-proportioned drive
// Assumes: settings are already range checked by the register block
// Notes:   output is registered; stop clears the period counters
`timescale 1ns/1ps
module tlc_loop #(
  parameter int CYC_PER_MS = tlc_pkg::CYC_PER_MS
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic                   run,
  input  wire logic                   onoff,
  input  wire logic                   forward,
  input  wire logic signed [15:0]     measured_temperature,
  input  wire tlc_pkg::tlc_loop_set_t set,
  output logic                        loop_out
);

  localparam int CW = $clog2(CYC_PER_MS + 1);

  typedef struct packed {
    logic [CW-1:0] cyc;
    logic [6:0]    ms;
    logic [9:0]    slot;
    logic          out;
  } tlc_loop_st_t;

  tlc_loop_st_t st_r;
  tlc_loop_st_t st_nxt;
  logic signed [17:0] pv;
  logic signed [17:0] sp;
  logic signed [17:0] bw;

  // widened so that target plus band never wraps
  assign pv = 18'(measured_temperature);
  assign sp = 18'(signed'(set.target));
  assign bw = 18'(set.band);

  // next state: phase counters and the output decision
  always_comb
  begin
    st_nxt = st_r;
    if (!run)
    begin
      st_nxt = '0;
    end
    else if (onoff)
    begin
      if (!forward)
      begin
        if (st_r.out && pv >= sp)
          st_nxt.out = 1'b0;
        else if (!st_r.out && pv < sp - bw)
          st_nxt.out = 1'b1;
      end
      else
      begin
        if (st_r.out && pv <= sp)
          st_nxt.out = 1'b0;
        else if (!st_r.out && pv > sp + bw)
          st_nxt.out = 1'b1;
      end
    end
    else
    begin
      // one slot lasts period milliseconds, so 1000 slots make one period
      if (st_r.cyc >= CW'(CYC_PER_MS - 1))
      begin
        st_nxt.cyc = '0;
        if (st_r.ms >= 7'(set.period - 16'h0001))
        begin
          st_nxt.ms = '0;
          st_nxt.slot = (st_r.slot >= 10'(tlc_pkg::SLOTS_PER_PERIOD - 1)) ? '0 : st_r.slot + 10'h001;
        end
        else
          st_nxt.ms = st_r.ms + 7'h01;
      end
      else
        st_nxt.cyc = st_r.cyc + CW'(1);
      st_nxt.out = (16'(st_nxt.slot) < set.drive);
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign loop_out = st_r.out;

endmodule // tlc_loop

// file: hw/tlc_ctl.sv
// Purpose: configuration capture, apb registers and two control loops
// Assumes: front-panel inputs are synchronous to mclk and steady around reset
// Notes:   period, band and drive settings are range checked (target is not); a bad write is refused and flagged
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tlc_ctl #(
  parameter int   CYC_PER_MS  = tlc_pkg::CYC_PER_MS,
  parameter bit   RTD_VARIANT = 1'b0
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // front panel
  input  wire logic [3:0]         panel_input_type,
  input  wire logic [7:0]         panel_switch,
  // sensor values and loop outputs
  input  wire logic signed [15:0] measured_temperature1,
  input  wire logic signed [15:0] measured_temperature2,
  output logic [1:0]              loop_out
);

  generate
    if (CYC_PER_MS < 1 || CYC_PER_MS > 65535)
    begin : g_bad_param
      $error("CYC_PER_MS must lie between 1 and 65535");
    end
    // the loop counts milliseconds of one slot in a 7-bit counter
    if (int'(tlc_pkg::PERIOD_MAX) > 128 || int'(tlc_pkg::PERIOD_MIN) < 1)
    begin : g_bad_period
      $error("period limits do not fit the loop millisecond counter");
    end
    // slots are counted in 10 bits; a drive above the slot count means nothing
    if (int'(tlc_pkg::DRIVE_MAX) > tlc_pkg::SLOTS_PER_PERIOD || tlc_pkg::SLOTS_PER_PERIOD > 1024)
    begin : g_bad_slots
      $error("drive limit or slot count does not fit the slot counter");
    end
  endgenerate

  typedef struct packed {
    tlc_pkg::tlc_cfg_t            cfg;
    logic [1:0]                   stop;
    tlc_pkg::tlc_loop_set_t [1:0] set;
    logic                         err_flag;
    logic [3:0]                   err_num;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
  } tlc_ctl_st_t;

  tlc_ctl_st_t        st_r;
  tlc_ctl_st_t        st_nxt;
  tlc_pkg::tlc_cfg_t  cfg_now;
  logic               access;
  logic               type_ok;
  logic               mapped;
  logic [15:0]        wd;
  logic [31:0]        status;
  logic [31:0]        rd;
  logic signed [15:0] pv [2];

  assign pv[0] = measured_temperature1;
  assign pv[1] = measured_temperature2;

  // panel pins as they stand now; only the reset branch looks at them
  always_comb
  begin
    cfg_now.input_type  = panel_input_type;
    cfg_now.fahrenheit  = panel_switch[1];
    cfg_now.data_format = panel_switch[2];
    cfg_now.forward     = panel_switch[4:3];
    cfg_now.onoff       = panel_switch[5];
  end

  // a code outside the variant's table blocks both loops
  assign type_ok = RTD_VARIANT ? (st_r.cfg.input_type <= tlc_pkg::RTD_TYPE_MAX)
                               : (st_r.cfg.input_type <= tlc_pkg::TC_TYPE_MAX);

  // the write takes effect at the edge that completes the access phase
  assign access = psel && penable && st_r.pready;
  assign wd     = pwdata[15:0];

  // status word shows the caught configuration and loop state
  always_comb
  begin
    status = '0;
    status[tlc_pkg::ST_TYPE_LSB +: 4] = st_r.cfg.input_type;
    status[tlc_pkg::ST_FAHR]          = st_r.cfg.fahrenheit;
    status[tlc_pkg::ST_FMT]           = st_r.cfg.data_format;
    status[tlc_pkg::ST_FWD_LSB +: 2]  = st_r.cfg.forward;
    status[tlc_pkg::ST_ONOFF]         = st_r.cfg.onoff;
    status[tlc_pkg::ST_BADTYPE]       = !type_ok;
    status[tlc_pkg::ST_ERR]           = st_r.err_flag;
    status[tlc_pkg::ST_ERRN_LSB +: 4] = st_r.err_num;
    status[tlc_pkg::ST_OUT_LSB +: 2]  = loop_out;
  end

  // read mux; unmapped addresses answer zero with an error
  always_comb
  begin
    rd = '0;
    mapped = 1'b1;
    case (paddr)
      tlc_pkg::OFS_CTRL:    rd = {30'h0, st_r.stop};
      tlc_pkg::OFS_STATUS:  rd = status;
      tlc_pkg::OFS_PERIOD1: rd = {16'h0, st_r.set[0].period};
      tlc_pkg::OFS_PERIOD2: rd = {16'h0, st_r.set[1].period};
      tlc_pkg::OFS_TARGET1: rd = {16'h0, st_r.set[0].target};
      tlc_pkg::OFS_TARGET2: rd = {16'h0, st_r.set[1].target};
      tlc_pkg::OFS_BAND1:   rd = {16'h0, st_r.set[0].band};
      tlc_pkg::OFS_BAND2:   rd = {16'h0, st_r.set[1].band};
      tlc_pkg::OFS_DRIVE1:  rd = {16'h0, st_r.set[0].drive};
      tlc_pkg::OFS_DRIVE2:  rd = {16'h0, st_r.set[1].drive};
      default:              mapped = 1'b0;
    endcase
  end

  // next state: bus handshake, register writes and range checks
  always_comb
  begin
    st_nxt = st_r;
    // pready rises in the first access cycle, so each transfer has no wait state
    st_nxt.pready = psel && !penable;
    if (psel && !penable)
    begin
      st_nxt.prdata  = pwrite ? 32'h0 : rd;
      st_nxt.pslverr = !mapped;
    end
    else if (access)
    begin
      st_nxt.prdata  = '0;
      st_nxt.pslverr = 1'b0;
    end
    if (access && pwrite && mapped)
    begin
      case (paddr)
        tlc_pkg::OFS_CTRL:
          st_nxt.stop = pwdata[1:0];
        tlc_pkg::OFS_STATUS:
          if (pwdata[tlc_pkg::ST_ERR])
            st_nxt.err_flag = 1'b0;
        tlc_pkg::OFS_PERIOD1, tlc_pkg::OFS_PERIOD2:
          if (wd >= tlc_pkg::PERIOD_MIN && wd <= tlc_pkg::PERIOD_MAX)
            st_nxt.set[paddr[2]].period = wd;
          else
          begin
            st_nxt.err_flag = 1'b1;
            st_nxt.err_num  = tlc_pkg::ERRN_PERIOD;
          end
        tlc_pkg::OFS_TARGET1, tlc_pkg::OFS_TARGET2:
          st_nxt.set[paddr[2]].target = wd;
        tlc_pkg::OFS_BAND1, tlc_pkg::OFS_BAND2:
          if (wd <= tlc_pkg::BAND_MAX)
            st_nxt.set[paddr[2]].band = wd;
          else
          begin
            st_nxt.err_flag = 1'b1;
            st_nxt.err_num  = tlc_pkg::ERRN_BAND;
          end
        tlc_pkg::OFS_DRIVE1, tlc_pkg::OFS_DRIVE2:
          if (wd <= tlc_pkg::DRIVE_MAX)
            st_nxt.set[paddr[2]].drive = wd;
          else
          begin
            st_nxt.err_flag = 1'b1;
            st_nxt.err_num  = tlc_pkg::ERRN_DRIVE;
          end
        default:
          st_nxt.stop = st_r.stop;
      endcase
    end
  end

  // state register; panel values are caught only while reset is held
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r          <= '0;
      st_r.cfg      <= cfg_now;
      st_r.stop     <= tlc_pkg::RST_STOP;
      st_r.set[0]   <= {tlc_pkg::RST_PERIOD, tlc_pkg::RST_TARGET, tlc_pkg::RST_BAND, tlc_pkg::RST_DRIVE};
      st_r.set[1]   <= {tlc_pkg::RST_PERIOD, tlc_pkg::RST_TARGET, tlc_pkg::RST_BAND, tlc_pkg::RST_DRIVE};
    end
    else if (ce)
      st_r <= st_nxt;
  end

  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;

  // one loop engine per channel; band is ignored inside under time-proportioned drive
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_loop
      tlc_loop #(
        .CYC_PER_MS (CYC_PER_MS)
      ) u_loop (
        .mclk                 (mclk),
        .rstn                 (rstn),
        .ce                   (ce),
        .run                  (!st_r.stop[i] && type_ok),
        .onoff                (st_r.cfg.onoff),
        .forward              (st_r.cfg.forward[i]),
        .measured_temperature (pv[i]),
        .set                  (st_r.set[i]),
        .loop_out             (loop_out[i])
      );
    end
  endgenerate

endmodule // tlc_ctl

// file: testbench/tlc_ctl_monitor.sv
// Purpose: port checks of the temperature control block
// Assumes: ce is held high by the bench
// Notes:   bound onto every tlc_ctl instance
`timescale 1ns/1ps
module tlc_ctl_monitor (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  loop_out
);
  // all checks sample on mclk and rest while reset is applied
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic mapped;
  // implemented word addresses; anything else must be refused
  assign mapped = paddr inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};

  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("pready missing after a setup cycle");
  a_ready_single: assert property (pready && ce |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
    else $error("pready without a pending transfer");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("bus error on a mapped register");
  a_idle_data: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside the answer cycle");
  a_release_idle: assert property ($rose(rstn) |-> (loop_out == 2'h0) [*2])
    else $error("loop output active straight after reset");
  a_stop_clears: assert property (psel && penable && pready && pwrite && paddr == 8'h00
    && pwdata[1:0] == 2'h3 |-> ##3 loop_out == 2'h0)
    else $error("loop output still active after stop");
endmodule // tlc_ctl_monitor

bind tlc_ctl tlc_ctl_monitor u_mon (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .loop_out(loop_out));

// file: testbench/tlc_host.sv
// Purpose: host controller that exchanges setting words over apb
// Assumes: slave answers with registered pready
// Notes:   one idle cycle between transfers keeps psel edges clean
`timescale 1ns/1ps
module tlc_host (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk iff pready);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // tlc_host

// file: testbench/tlc_tb_top.sv
// Purpose: self-checking bench of the temperature control block
// Assumes: thermocouple variant, shortened millisecond count
// Notes:   panel values are changed after reset to show they are ignored
`timescale 1ns/1ps
module tb_top;
  logic               mclk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]         paddr, psw;
  logic [3:0]         ptype;
  logic [31:0]        pwdata, prdata, rd, hi1, hi2;
  logic signed [15:0] pv1, pv2;
  logic [1:0]         loop_out, rtd_loop_out;
  int                 miscompares, n_checks, cyc;
  logic [31:0]        rst_v [8] = '{32'h14, 32'h14, 32'h0, 32'h0, 32'h8, 32'h8, 32'h0, 32'h0};
  logic [7:0]         ea [4] = '{8'h10, 8'h14, 8'h20, 8'h28};
  logic [31:0]        ev [4] = '{32'h0, 32'h64, 32'h2710, 32'h3e9};
  logic [31:0]        eo [4] = '{32'h14, 32'h14, 32'h8, 32'h0};
  logic [31:0]        en [4] = '{32'h1, 32'h1, 32'h3, 32'h4};

  tlc_ctl #(.CYC_PER_MS(2), .RTD_VARIANT(1'b0)) uut (.mclk(mclk), .rstn(rstn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .panel_input_type(ptype), .panel_switch(psw), .measured_temperature1(pv1),
    .measured_temperature2(pv2), .loop_out(loop_out));
  tlc_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // resistance variant beside it on the same pins; only codes 0 and 1 may let its loops run
  tlc_ctl #(.CYC_PER_MS(2), .RTD_VARIANT(1'b1)) uut_rtd (.mclk(mclk), .rstn(rstn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .panel_input_type(ptype), .panel_switch(psw), .measured_temperature1(pv1), .measured_temperature2(pv2),
    .loop_out(rtd_loop_out));

  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test;
    end
  end

  task end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t ns got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, rerr);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd, rerr);
    chk(rd, exp);
  endtask

  // panel values are applied with reset and left on the pins after release
  task do_reset(input logic [3:0] t, input logic [7:0] s);
    @(posedge mclk);
    rstn  <= 1'b0;
    ptype <= t;
    psw   <= s;
    repeat (5) @(posedge mclk);
    rstn  <= 1'b1;
  endtask

  // apply process values, let the registered outputs settle, compare
  task pvs(input logic signed [15:0] a, input logic signed [15:0] b, input logic [1:0] e);
    pv1 <= a;
    pv2 <= b;
    repeat (3) @(posedge mclk);
    chk({30'h0, loop_out}, {30'h0, e});
  endtask

  // main sequence
  initial
  begin
    rstn = 1'b0; ptype = 4'h0; psw = 8'h0; pv1 = 16'sh0; pv2 = 16'sh0;
    cyc = 0; miscompares = 0; n_checks = 0;
    do_reset(4'h3, 8'h2e);
    ptype <= 4'h7;
    psw   <= 8'h04;
    rchk(tlc_pkg::OFS_STATUS, 32'h173);
    rchk(tlc_pkg::OFS_CTRL, 32'h3);
    for (int i = 0; i < 8; i++)
      rchk(8'h10 + 8'(4 * i), rst_v[i]);
    wr(8'h30, 32'h5);
    chk({31'h0, rerr}, 32'h1);
    rchk(8'h30, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // each refused write keeps the old value and reports its number
    for (int i = 0; i < 4; i++)
    begin
      wr(ea[i], ev[i]);
      rchk(ea[i], eo[i]);
      rchk(tlc_pkg::OFS_STATUS, 32'h573 | (en[i] << 12));
      wr(tlc_pkg::OFS_STATUS, 32'h400);
      rchk(tlc_pkg::OFS_STATUS, 32'h173 | (en[i] << 12));
    end
    wr(tlc_pkg::OFS_PERIOD1, 32'h63);
    rchk(tlc_pkg::OFS_PERIOD1, 32'h63);
    // on/off: loop 1 forward around 100, loop 2 reverse around -20, band 10
    wr(tlc_pkg::OFS_TARGET1, 32'h64);
    wr(tlc_pkg::OFS_TARGET2, 32'hffec);
    wr(tlc_pkg::OFS_BAND1, 32'ha);
    wr(tlc_pkg::OFS_BAND2, 32'ha);
    pvs(16'sd150, -16'sd50, 2'h0);
    wr(tlc_pkg::OFS_CTRL, 32'h0);
    pvs(16'sd150, -16'sd50, 2'h3);
    chk({30'h0, rtd_loop_out}, 32'h0);
    pvs(16'sd105, -16'sd25, 2'h3);
    pvs(16'sd100, -16'sd20, 2'h0);
    pvs(16'sd110, -16'sd30, 2'h0);
    pvs(16'sd111, -16'sd31, 2'h3);
    rchk(tlc_pkg::OFS_STATUS, 32'h34173);
    wr(tlc_pkg::OFS_CTRL, 32'h3);
    pvs(16'sd111, -16'sd31, 2'h0);
    // an invalid code is flagged and keeps both loops off
    do_reset(4'ha, 8'h24);
    rchk(tlc_pkg::OFS_STATUS, 32'h32a);
    wr(tlc_pkg::OFS_CTRL, 32'h0);
    pvs(-16'sd100, -16'sd100, 2'h0);
    // time-proportioned output: 25 percent and full drive
    do_reset(4'h0, 8'h04);
    wr(tlc_pkg::OFS_PERIOD1, 32'h1);
    wr(tlc_pkg::OFS_DRIVE1, 32'hfa);
    wr(tlc_pkg::OFS_PERIOD2, 32'h2);
    wr(tlc_pkg::OFS_DRIVE2, 32'h3e8);
    wr(tlc_pkg::OFS_CTRL, 32'h0);
    hi1 = 32'h0;
    hi2 = 32'h0;
    repeat (4) @(posedge mclk);
    repeat (2000)
    begin
      @(posedge mclk);
      hi1 = hi1 + loop_out[0];
      hi2 = hi2 + loop_out[1];
    end
    chk(hi1, 32'd500);
    chk(hi2, 32'd2000);
    chk({31'h0, rtd_loop_out[1]}, 32'h1);
    end_of_test;
  end
endmodule // tb_top
